// >>> shared/umlb_pkg.sv
// Constants, states and register map of the serial port register block
//-----------------------------------------------------------------------
// Contract
// - MC bits 0,1 drive active-low ready/request pins
// - MC bit 3 floats or enables interrupt pin
// - Loopback: line marks, tx shifter feeds rx
// - Loopback: pins inactive, status mirrors control bits
// - Loopback modem events come from control bits
// - MC bits 5 to 7 read zero
// - Data ready on char arrival, cleared by read
// - Overrun when unread char overwritten, clear on read
// - Parity fault flagged, cleared on line-status read
// - Framing fault; resample zero as next start
// - Break: one zero char, half-bit high restart
// - Line errors raise line-status interrupt when enabled
// - Hold-empty set on transfer, cleared on write
// - All-empty only when hold and shifter empty
// - Line status bit 7 zero without FIFO
// - CTS/DSR/DCD change bits, clear on read
// - Ring trailing edge flag, clear on read
// - Status high nibble shows inverted input pins
// - Eight-bit scratch register, no side effect
// - Sixteen-bit divisor, write reloads counter at once
// - Divisor 0,1,2 and 3+ output shapes
// - Divider input is crystal over thirteen
// - Line status resets to hold and all empty
//-----------------------------------------------------------------------
package umlb_pkg;
	localparam logic [2:0] OFS_DATA    = 3'h0; // Rx/Tx data, divisor low
	localparam logic [2:0] OFS_IEN     = 3'h1; // Irq enable, divisor high
	localparam logic [2:0] OFS_IID     = 3'h2; // Irq ident read
	localparam logic [2:0] OFS_LCTL    = 3'h3; // Line control
	localparam logic [2:0] OFS_MCTL    = 3'h4; // Modem control
	localparam logic [2:0] OFS_LSTAT   = 3'h5; // Line status
	localparam logic [2:0] OFS_MSTAT   = 3'h6; // Modem status
	localparam logic [2:0] OFS_SCRATCH = 3'h7; // Scratch
	localparam int LC_ACCESS = 7;               // Divisor access bit
	localparam int LC_BREAK  = 6;               // Force spacing
	localparam int LC_STICK  = 5;               // Stick parity
	localparam int LC_EVEN   = 4;               // Even parity
	localparam int LC_PAREN  = 3;               // Parity enable
	localparam int LC_STOP2  = 2;               // Long stop
	localparam int MC_LOOP   = 4;               // Loopback bit
	localparam int MC_GATE   = 3;               // Irq gate bit
	localparam logic [7:0] LSTAT_RESET = 8'h60; // Both empty bits set
	localparam logic [3:0] IID_NONE = 4'h1;     // No interrupt
	localparam logic [3:0] IID_LINE = 4'h6;     // Line status
	localparam logic [3:0] IID_RXD  = 4'h4;     // Data ready
	localparam logic [3:0] IID_TX_HOLD_EMPTY = 4'h2;     // Hold empty
	localparam logic [3:0] IID_MDM  = 4'h0;     // Modem status
	localparam int SYS_CLK_HZ = 50_000_000;     // System clock
	localparam int XTAL_HZ    = 24_000_000;     // Crystal figure
	localparam int XTAL_DIV   = 13;             // Crystal divide
	localparam int BAUD_IN_HZ = XTAL_HZ / XTAL_DIV;
	localparam int PRE_DIV    = SYS_CLK_HZ / BAUD_IN_HZ; // Cycles per input tick
	localparam int HALF_BIT   = 8;              // Ticks in half a bit
	typedef enum logic [2:0] {
		UMLB_RX_IDLE  = 3'b000,
		UMLB_RX_START = 3'b001,
		UMLB_RX_DATA  = 3'b010,
		UMLB_RX_PAR   = 3'b011,
		UMLB_RX_STOP  = 3'b100,
		UMLB_RX_BRK   = 3'b101
	} umlb_rx_t;
	typedef enum logic [2:0] {
		UMLB_TX_IDLE  = 3'b000,
		UMLB_TX_START = 3'b001,
		UMLB_TX_DATA  = 3'b010,
		UMLB_TX_PAR   = 3'b011,
		UMLB_TX_STOP  = 3'b100
	} umlb_tx_t;
endpackage

// >>> rtl/umlb_uart.sv
// Serial port: registers, baud divider, transmitter, receiver, modem lines
`timescale 1ns/1ps
module umlb_uart (
	input  wire logic                 sys_clk,             // System clock
	input  wire logic                 resetn,              // Async reset, low
	input  wire logic [2:0]           reg_addr,            // Register offset
	input  wire logic [7:0]           reg_wdata,           // Write data
	input  wire logic                 reg_wr,              // Write strobe
	input  wire logic                 reg_rd,              // Read strobe
	output logic      [7:0]           reg_rdata,           // Read data, next cycle
	input  wire logic                 rx_in,               // Serial input pin
	output logic                      tx_out,              // Serial output pin
	input  wire logic                 clear_to_send_in_n,  // Modem pin
	input  wire logic                 set_ready_in_n,      // Modem pin
	input  wire logic                 ring_in_n,           // Modem pin
	input  wire logic                 carrier_detect_in_n, // Modem pin
	output logic                      terminal_ready_out_n,// Modem pin
	output logic                      request_send_out_n,  // Modem pin
	output logic                      irq_out,             // Interrupt level
	output logic                      irq_oe_n,            // Irq drive, low drives
	output logic                      baud_out             // Divider output
);
	import umlb_pkg::*;

	//-------------------------------------------------------------------
	// Register state
	//-------------------------------------------------------------------
	logic [7:0] rbuf_reg, rbuf_next;     // Received char
	logic [7:0] tx_hold_reg, tx_hold_next;
	logic [7:0] ien_reg, ien_next;       // Irq enables, low nibble used
	logic [7:0] lctl_reg, lctl_next;
	logic [4:0] mctl_reg, mctl_next;     // Only five bits exist
	logic [7:0] scratch_reg, scratch_next;
	logic [7:0] div_lo_reg, div_lo_next;
	logic [7:0] div_hi_reg, div_hi_next;
	logic [4:0] lstat_reg, lstat_next;   // Data ready and four errors
	logic       tx_hold_empty_reg, tx_hold_empty_next;
	logic       tx_hold_empty_irq_reg, tx_hold_empty_irq_next;
	logic [3:0] delta_reg, delta_next;   // Modem change flags
	logic [7:0] rdata_reg, rdata_next;
	logic       reload;                  // Divisor written
	logic [7:0] lstat_rd, mstat_rd;      // Read views
	logic [3:0] iid;                     // Ident code

	//-------------------------------------------------------------------
	// Pin synchronisers and modem sources
	//-------------------------------------------------------------------
	logic [4:0] sy1_reg, sy2_reg;        // {rx, dcd, ri, dsr, cts}
	logic [3:0] prev_reg;                // Last active levels
	logic [3:0] act;                     // Active modem levels
	logic [3:0] chg;                     // Change events
	logic       loop;
	logic       rx_src;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sy1_reg  <= 5'h1f;
			sy2_reg  <= 5'h1f;
			prev_reg <= 4'h0;
		end else begin
			sy1_reg  <= {rx_in, carrier_detect_in_n, ring_in_n,
				set_ready_in_n, clear_to_send_in_n};
			sy2_reg  <= sy1_reg;
			prev_reg <= act;
		end
	end

	assign loop = mctl_reg[MC_LOOP];
	// Loopback mirrors control bits onto status inputs
	always_comb begin
		if (loop) begin
			act = {mctl_reg[3], mctl_reg[2], mctl_reg[0], mctl_reg[1]};
		end else begin
			act = ~sy2_reg[3:0];
		end
		chg[0] = act[0] ^ prev_reg[0];
		chg[1] = act[1] ^ prev_reg[1];
		chg[2] = prev_reg[2] & ~act[2];
		chg[3] = act[3] ^ prev_reg[3];
	end

	// Pins forced inactive in loopback
	assign terminal_ready_out_n = loop | ~mctl_reg[0];
	assign request_send_out_n   = loop | ~mctl_reg[1];

	//-------------------------------------------------------------------
	// Baud divider
	//-------------------------------------------------------------------
	logic [4:0]  pre_reg, pre_next;      // Input clock prescale
	logic [15:0] bcnt_reg, bcnt_next;    // Baud counter
	logic        bout_reg, bout_next;
	logic        tick_reg, tick_next;    // Sixteen-times-baud tick
	logic [15:0] divisor, eff, div_new;
	logic        in_tick;

	assign divisor = {div_hi_reg, div_lo_reg};
	assign eff     = (divisor == 16'h0000) ? 16'h0003 : divisor;
	assign div_new = {div_hi_next, div_lo_next}; // Value being written
	assign in_tick = (pre_reg == 5'(PRE_DIV - 1));

	// Counter reloads on each divisor write so no long first count
	always_comb begin
		pre_next  = in_tick ? 5'h00 : pre_reg + 5'h01;
		bcnt_next = bcnt_reg;
		tick_next = 1'b0;
		if (reload) begin
			bcnt_next = (div_new == 16'h0000) ? 16'h0003 : div_new;
		end else if (in_tick) begin
			if (bcnt_reg <= 16'h0001) begin
				bcnt_next = eff;
				tick_next = 1'b1;
			end else begin
				bcnt_next = bcnt_reg - 16'h0001;
			end
		end
		if (eff == 16'h0001) begin
			bout_next = ~(pre_reg < 5'(PRE_DIV / 2));
		end else if (eff == 16'h0002) begin
			bout_next = (bcnt_reg == 16'h0002);
		end else begin
			bout_next = (bcnt_reg > 16'h0002);
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pre_reg  <= 5'h00;
			bcnt_reg <= 16'h0003;
			bout_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			pre_reg  <= pre_next;
			bcnt_reg <= bcnt_next;
			bout_reg <= bout_next;
			tick_reg <= tick_next;
		end
	end
	assign baud_out = bout_reg;

	//-------------------------------------------------------------------
	// Transmitter
	//-------------------------------------------------------------------
	umlb_tx_t   txs_reg, txs_next;
	logic [7:0] tsh_reg, tsh_next;       // Shift register
	logic [5:0] tcnt_reg, tcnt_next;     // Ticks within bit
	logic [2:0] tbit_reg, tbit_next;
	logic       tline_reg, tline_next;   // Shifter output
	logic       tpar_reg, tpar_next;     // Running parity
	logic       tx_load;                 // Hold moves to shifter
	logic [2:0] last_bit;
	logic [5:0] stop_len;

	assign last_bit = {1'b0, lctl_reg[1:0]} + 3'h4;
	// With long stop set, five-bit words get one and a half stop bits
	assign stop_len = !lctl_reg[LC_STOP2] ? 6'h0f :
		(lctl_reg[1:0] == 2'h0) ? 6'h17 : 6'h1f;
	assign tx_load  = (txs_reg == UMLB_TX_IDLE) && !tx_hold_empty_reg;

	always_comb begin
		txs_next   = txs_reg;
		tsh_next   = tsh_reg;
		tcnt_next  = tcnt_reg;
		tbit_next  = tbit_reg;
		tline_next = tline_reg;
		tpar_next  = tpar_reg;
		case (txs_reg)
			UMLB_TX_IDLE: begin
				tline_next = 1'b1;
				if (tx_load) begin
					tsh_next  = tx_hold_reg;
					tcnt_next = 6'h00;
					tpar_next = 1'b0;
					txs_next  = UMLB_TX_START;
					tline_next = 1'b0;
				end
			end
			UMLB_TX_START, UMLB_TX_DATA, UMLB_TX_PAR: begin
				if (tick_reg) begin
					tcnt_next = tcnt_reg + 6'h01;
					if (tcnt_reg == 6'h0f) begin
						tcnt_next = 6'h00;
						if (txs_reg == UMLB_TX_START) begin
							tbit_next = 3'h0;
							txs_next  = UMLB_TX_DATA;
							tline_next = tsh_reg[0];
						end else if (txs_reg == UMLB_TX_DATA &&
								tbit_reg != last_bit) begin
							tbit_next  = tbit_reg + 3'h1;
							tline_next = tsh_reg[tbit_reg + 3'h1];
						end else if (txs_reg == UMLB_TX_DATA &&
								lctl_reg[LC_PAREN]) begin
							txs_next = UMLB_TX_PAR;
							tline_next = lctl_reg[LC_STICK] ? ~lctl_reg[LC_EVEN]
								: tpar_reg ^ tline_reg ^ ~lctl_reg[LC_EVEN];
						end else begin
							txs_next   = UMLB_TX_STOP;
							tline_next = 1'b1;
						end
						if (txs_reg == UMLB_TX_DATA) begin
							tpar_next = tpar_reg ^ tline_reg;
						end
					end
				end
			end
			UMLB_TX_STOP: begin
				if (tick_reg) begin
					tcnt_next = tcnt_reg + 6'h01;
					if (tcnt_reg == stop_len) begin
						txs_next = UMLB_TX_IDLE;
					end
				end
			end
			default: txs_next = UMLB_TX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			txs_reg   <= UMLB_TX_IDLE;
			tsh_reg   <= 8'h00;
			tcnt_reg  <= 6'h00;
			tbit_reg  <= 3'h0;
			tline_reg <= 1'b1;
			tpar_reg  <= 1'b0;
		end else begin
			txs_reg   <= txs_next;
			tsh_reg   <= tsh_next;
			tcnt_reg  <= tcnt_next;
			tbit_reg  <= tbit_next;
			tline_reg <= tline_next;
			tpar_reg  <= tpar_next;
		end
	end
	// Line marks in loopback; break forces spacing otherwise
	assign tx_out = loop | (tline_reg & ~lctl_reg[LC_BREAK]);

	//-------------------------------------------------------------------
	// Receiver
	//-------------------------------------------------------------------
	umlb_rx_t   rxs_reg, rxs_next;
	logic [7:0] rsh_reg, rsh_next;
	logic [3:0] rcnt_reg, rcnt_next;
	logic [2:0] rbit_reg, rbit_next;
	logic       rpar_reg, rpar_next;     // Data parity
	logic       rbad_reg, rbad_next;     // Parity fault
	logic       rzero_reg, rzero_next;   // All bits zero so far
	logic       rx_done;                 // Char complete
	logic       rx_fe, rx_bi;

	assign rx_src = loop ? tline_reg : sy2_reg[4];

	always_comb begin
		rxs_next   = rxs_reg;
		rsh_next   = rsh_reg;
		rcnt_next  = rcnt_reg;
		rbit_next  = rbit_reg;
		rpar_next  = rpar_reg;
		rbad_next  = rbad_reg;
		rzero_next = rzero_reg;
		rx_done    = 1'b0;
		rx_fe      = 1'b0;
		rx_bi      = 1'b0;
		if (tick_reg) begin
			rcnt_next = rcnt_reg + 4'h1;
			case (rxs_reg)
				UMLB_RX_IDLE: begin
					rcnt_next = 4'h0;
					if (!rx_src) begin
						rxs_next = UMLB_RX_START;
					end
				end
				UMLB_RX_START: begin
					// Mid-bit check rejects glitches
					if (rcnt_reg == 4'h7) begin
						rcnt_next  = 4'h0;
						rbit_next  = 3'h0;
						rpar_next  = 1'b0;
						rbad_next  = 1'b0;
						rzero_next = 1'b1;
						rsh_next   = 8'h00;
						rxs_next   = rx_src ? UMLB_RX_IDLE : UMLB_RX_DATA;
					end
				end
				UMLB_RX_DATA: begin
					if (rcnt_reg == 4'hf) begin
						rsh_next[rbit_reg] = rx_src;
						rpar_next  = rpar_reg ^ rx_src;
						rzero_next = rzero_reg & ~rx_src;
						rbit_next  = rbit_reg + 3'h1;
						if (rbit_reg == last_bit) begin
							rxs_next = lctl_reg[LC_PAREN] ? UMLB_RX_PAR : UMLB_RX_STOP;
						end
					end
				end
				UMLB_RX_PAR: begin
					if (rcnt_reg == 4'hf) begin
						rzero_next = rzero_reg & ~rx_src;
						rbad_next  = lctl_reg[LC_STICK] ? rx_src ^ ~lctl_reg[LC_EVEN]
							: rpar_reg ^ rx_src ^ ~lctl_reg[LC_EVEN];
						rxs_next = UMLB_RX_STOP;
					end
				end
				UMLB_RX_STOP: begin
					if (rcnt_reg == 4'hf) begin
						rx_done   = 1'b1;
						rcnt_next = 4'h0;
						if (!rx_src && rzero_reg) begin
							rx_bi    = 1'b1;
							rsh_next = 8'h00;
							rxs_next = UMLB_RX_BRK;
						end else if (!rx_src) begin
							// Take the low stop as a fresh start bit
							rx_fe    = 1'b1;
							rxs_next = UMLB_RX_START;
						end else begin
							rxs_next = UMLB_RX_IDLE;
						end
					end
				end
				UMLB_RX_BRK: begin
					// Needs a steady half bit of mark to rearm
					if (!rx_src) begin
						rcnt_next = 4'h0;
					end else if (rcnt_reg == 4'(HALF_BIT - 1)) begin
						rxs_next = UMLB_RX_IDLE;
					end
				end
				default: rxs_next = UMLB_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rxs_reg   <= UMLB_RX_IDLE;
			rsh_reg   <= 8'h00;
			rcnt_reg  <= 4'h0;
			rbit_reg  <= 3'h0;
			rpar_reg  <= 1'b0;
			rbad_reg  <= 1'b0;
			rzero_reg <= 1'b0;
		end else begin
			rxs_reg   <= rxs_next;
			rsh_reg   <= rsh_next;
			rcnt_reg  <= rcnt_next;
			rbit_reg  <= rbit_next;
			rpar_reg  <= rpar_next;
			rbad_reg  <= rbad_next;
			rzero_reg <= rzero_next;
		end
	end

	//-------------------------------------------------------------------
	// Register file, flags and interrupt
	//-------------------------------------------------------------------
	logic divisor_access_bit, rd_data, rd_lstat, rd_mstat, rd_iid, wr_hold;
	logic line_irq, rxd_irq, tx_hold_empty_irq, mdm_irq;

	assign divisor_access_bit     = lctl_reg[LC_ACCESS];
	assign rd_data  = reg_rd && reg_addr == OFS_DATA && !divisor_access_bit;
	assign rd_lstat = reg_rd && reg_addr == OFS_LSTAT;
	assign rd_mstat = reg_rd && reg_addr == OFS_MSTAT;
	assign rd_iid   = reg_rd && reg_addr == OFS_IID;
	assign wr_hold  = reg_wr && reg_addr == OFS_DATA && !divisor_access_bit;
	assign reload   = reg_wr && (reg_addr == OFS_DATA || reg_addr == OFS_IEN) && divisor_access_bit;

	// Bit 7 stays zero: no receive FIFO in this port
	assign lstat_rd = {1'b0, tx_hold_empty_reg && txs_reg == UMLB_TX_IDLE,
		tx_hold_empty_reg, lstat_reg};
	assign mstat_rd = {act, delta_reg};

	assign line_irq = ien_reg[2] && (|lstat_reg[4:1]);
	assign rxd_irq  = ien_reg[0] && lstat_reg[0];
	assign tx_hold_empty_irq = ien_reg[1] && tx_hold_empty_irq_reg;
	assign mdm_irq  = ien_reg[3] && (|delta_reg);
	assign iid = line_irq ? IID_LINE : rxd_irq ? IID_RXD :
		tx_hold_empty_irq ? IID_TX_HOLD_EMPTY : mdm_irq ? IID_MDM : IID_NONE;

	always_comb begin
		rbuf_next    = rbuf_reg;
		tx_hold_next = tx_hold_reg;
		ien_next     = ien_reg;
		lctl_next    = lctl_reg;
		mctl_next    = mctl_reg;
		scratch_next = scratch_reg;
		div_lo_next  = div_lo_reg;
		div_hi_next  = div_hi_reg;
		rdata_next   = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				OFS_DATA:    if (divisor_access_bit) div_lo_next = reg_wdata; else tx_hold_next = reg_wdata;
				OFS_IEN:     if (divisor_access_bit) div_hi_next = reg_wdata; else ien_next = {4'h0, reg_wdata[3:0]};
				OFS_LCTL:    lctl_next = reg_wdata;
				OFS_MCTL:    mctl_next = reg_wdata[4:0];
				OFS_SCRATCH: scratch_next = reg_wdata;
				default:     ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				OFS_DATA:    rdata_next = divisor_access_bit ? div_lo_reg : rbuf_reg;
				OFS_IEN:     rdata_next = divisor_access_bit ? div_hi_reg : ien_reg;
				OFS_IID:     rdata_next = {4'h0, iid};
				OFS_LCTL:    rdata_next = lctl_reg;
				OFS_MCTL:    rdata_next = {3'h0, mctl_reg};
				OFS_LSTAT:   rdata_next = lstat_rd;
				OFS_MSTAT:   rdata_next = mstat_rd;
				default:     rdata_next = scratch_reg;
			endcase
		end
		if (rx_done) begin
			rbuf_next = rsh_reg;
		end
		// Flags: a new event beats a clearing read in the same cycle
		lstat_next[0] = rx_done | (lstat_reg[0] & ~rd_data);
		lstat_next[1] = (rx_done & lstat_reg[0] & ~rd_data) |
			(lstat_reg[1] & ~rd_lstat);
		lstat_next[2] = (rx_done & rbad_reg) | (lstat_reg[2] & ~rd_lstat);
		lstat_next[3] = rx_fe | (lstat_reg[3] & ~rd_lstat);
		lstat_next[4] = rx_bi | (lstat_reg[4] & ~rd_lstat);
		// Write of a new char wins over the old one moving on
		tx_hold_empty_next = wr_hold ? 1'b0 : (tx_load | tx_hold_empty_reg);
		tx_hold_empty_irq_next = tx_load | (tx_hold_empty_irq_reg & ~wr_hold &
			~(rd_iid && iid == IID_TX_HOLD_EMPTY));
		delta_next = chg | (delta_reg & {4{~rd_mstat}});
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rbuf_reg          <= 8'h00;
			tx_hold_reg       <= 8'h00;
			ien_reg           <= 8'h00;
			lctl_reg          <= 8'h00;
			mctl_reg          <= 5'h00;
			scratch_reg       <= 8'h00;
			div_lo_reg        <= 8'h00;
			div_hi_reg        <= 8'h00;
			lstat_reg         <= LSTAT_RESET[4:0];
			tx_hold_empty_reg <= LSTAT_RESET[5];
			tx_hold_empty_irq_reg      <= 1'b0;
			delta_reg         <= 4'h0;
			rdata_reg         <= 8'h00;
		end else begin
			rbuf_reg          <= rbuf_next;
			tx_hold_reg       <= tx_hold_next;
			ien_reg           <= ien_next;
			lctl_reg          <= lctl_next;
			mctl_reg          <= mctl_next;
			scratch_reg       <= scratch_next;
			div_lo_reg        <= div_lo_next;
			div_hi_reg        <= div_hi_next;
			lstat_reg         <= lstat_next;
			tx_hold_empty_reg <= tx_hold_empty_next;
			tx_hold_empty_irq_reg      <= tx_hold_empty_irq_next;
			delta_reg         <= delta_next;
			rdata_reg         <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq_out   = (iid != IID_NONE);
	// Gate bit low leaves the interrupt pin floating
	assign irq_oe_n  = ~mctl_reg[MC_GATE];
endmodule

// >>> bench/umlb_uart_checker.sv
// Concurrent checks on the serial port register block ports
`timescale 1ns/1ps
module umlb_uart_checker
	import umlb_pkg::*;
(
	input wire logic       sys_clk,              // System clock
	input wire logic       resetn,               // Async reset, low
	input wire logic [2:0] reg_addr,             // Register offset
	input wire logic [7:0] reg_wdata,            // Write data
	input wire logic       reg_wr,               // Write strobe
	input wire logic       reg_rd,               // Read strobe
	input wire logic [7:0] reg_rdata,            // Read data
	input wire logic       tx_out,               // Serial output
	input wire logic       terminal_ready_out_n, // Ready pin
	input wire logic       request_send_out_n,   // Request pin
	input wire logic       irq_oe_n              // Irq drive enable
);
	//----------------------------------------
	// Shadow of modem control and its age
	//----------------------------------------
	logic [4:0] mc_reg, mc_next;   // Last written control bits
	logic [2:0] age_reg, age_next; // Cycles since control write, saturating
	// Age lets loopback status settle before it is judged
	always_comb begin
		mc_next = mc_reg;
		age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
		if (reg_wr && reg_addr == OFS_MCTL) begin
			mc_next = reg_wdata[4:0];
			age_next = 3'h0;
		end
	end
	// Register the shadow
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mc_reg <= 5'h00;
			age_reg <= 3'h0;
		end else begin
			mc_reg <= mc_next;
			age_reg <= age_next;
		end
	end
	//----------------------------------------
	// Assertions
	//----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_ready_pin_level: assert property (terminal_ready_out_n == (mc_reg[4] | !mc_reg[0]))
		else $error("ready pin does not follow control bit 0");
	a_request_pin_level: assert property (request_send_out_n == (mc_reg[4] | !mc_reg[1]))
		else $error("request pin does not follow control bit 1");
	a_irq_gate_drive: assert property (irq_oe_n == !mc_reg[MC_GATE])
		else $error("irq drive does not follow gate bit");
	a_loop_line_mark: assert property (mc_reg[MC_LOOP] |-> tx_out [*2])
		else $error("serial output not marking in loopback");
	a_control_read_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_MCTL
		|-> reg_rdata == {3'h0, $past(mc_reg)})
		else $error("modem control readback wrong");
	a_scratch_keeps_byte: assert property (reg_wr && reg_addr == OFS_SCRATCH ##2
		reg_rd && reg_addr == OFS_SCRATCH |=> reg_rdata == $past(reg_wdata, 3))
		else $error("scratch readback wrong");
	a_status_top_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_LSTAT
		|-> !reg_rdata[7])
		else $error("line status bit 7 set");
	a_loop_status_mirror: assert property ($past(reg_rd) && $past(reg_addr) == OFS_MSTAT
		&& $past(mc_reg[4]) && $past(age_reg) == 3'h7 |-> reg_rdata[7:4] ==
		{$past(mc_reg[3]), $past(mc_reg[2]), $past(mc_reg[0]), $past(mc_reg[1])})
		else $error("loopback modem status wrong");
endmodule

// >>> bench/umlb_modem_model.sv
// Modem and serial line partner for the serial port bench
`timescale 1ns/1ps
module umlb_modem_model #(
	parameter int BIT_CYC = 432 // System clocks per serial bit
) (
	input wire logic sys_clk,  // System clock
	output logic     rx_line,  // Serial line into the port, idles marking
	output logic     cts_n,    // Clear to send, active low
	output logic     dsr_n,    // Set ready, active low
	output logic     ri_n,     // Ring, active low
	output logic     dcd_n     // Carrier, active low
);
	initial begin
		rx_line = 1'b1;
		{dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
	end
	// Drive active levels {carrier, ring, ready, clear}
	task automatic set_lines(input logic [3:0] act);
		@(posedge sys_clk);
		{dcd_n, ri_n, dsr_n, cts_n} <= ~act;
	endtask
	// One 8N1 character, start low, LSB first, stop high
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
	endtask
endmodule

// >>> bench/umlb_uart_tb.sv
// Self-checking bench for the serial port register block
`timescale 1ns/1ps
module umlb_uart_tb;
	import umlb_pkg::*;
	logic       sys_clk = 1'b0;  // System clock
	logic       resetn = 1'b0;   // Async reset, low
	logic [2:0] reg_addr;        // Register offset
	logic [7:0] reg_wdata;       // Write data
	logic       reg_wr = 1'b0;   // Write strobe
	logic       reg_rd = 1'b0;   // Read strobe
	logic [7:0] reg_rdata;       // Read data
	logic       rx_in, tx_out, baud_out, irq_out, irq_oe_n; // Line and irq
	logic       clear_to_send_in_n, set_ready_in_n, ring_in_n, carrier_detect_in_n;
	logic       terminal_ready_out_n, request_send_out_n; // Modem outputs
	wire        irq_pin = irq_oe_n ? 1'bz : irq_out; // Resolved irq pin
	int         n_errors = 0;    // Mismatches
	int         n_checks = 0;    // Comparisons
	int         cyc = 0;         // Cycle count for the hang limit
	//----------------------------------------
	// Design, partner and clock
	//----------------------------------------
	umlb_uart DUT (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_in, .tx_out, .clear_to_send_in_n, .set_ready_in_n, .ring_in_n,
		.carrier_detect_in_n, .terminal_ready_out_n, .request_send_out_n, .irq_out,
		.irq_oe_n, .baud_out);
	umlb_modem_model #(.BIT_CYC(432)) modem (.sys_clk, .rx_line(rx_in),
		.cts_n(clear_to_send_in_n), .dsr_n(set_ready_in_n), .ri_n(ring_in_n),
		.dcd_n(carrier_detect_in_n));
	always #10 sys_clk = ~sys_clk;
	// Hang guard, far above the few thousand cycles a character takes
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			results();
		end
	end
	//----------------------------------------
	// Bus and compare tasks
	//----------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string nm,
		input logic [7:0] m = 8'hFF);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(nm, exp & m, reg_rdata & m);
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	//----------------------------------------
	// Scenarios
	//----------------------------------------
	task automatic t_reset_and_control();
		chk("ready_pin", 8'h01, {7'h0, terminal_ready_out_n});
		rdc(OFS_LSTAT, LSTAT_RESET, "line_status");
		wr(OFS_MCTL, 8'hFF);
		rdc(OFS_MCTL, 8'h1F, "modem_control");
		wr(OFS_MCTL, 8'h03);
		@(negedge sys_clk);
		chk("request_pin", 8'h00, {7'h0, request_send_out_n});
		chk("irq_pin", {7'h0, 1'bz}, {7'h0, irq_pin});
		wr(OFS_MCTL, 8'h08);
		@(negedge sys_clk);
		chk("irq_pin", 8'h00, {7'h0, irq_pin});
		chk("ready_pin", 8'h01, {7'h0, terminal_ready_out_n});
	endtask
	task automatic t_scratch();
		wr(OFS_SCRATCH, 8'hA5);
		rdc(OFS_SCRATCH, 8'hA5, "scratch");
		wr(OFS_LSTAT, 8'h1E);
		rdc(OFS_LSTAT, LSTAT_RESET, "line_status");
	endtask
	// Pin changes land in the change bits a few cycles later
	task automatic t_modem();
		rdc(OFS_MSTAT, 8'h00, "modem_status", 8'hF0);
		modem.set_lines(4'b0001);
		repeat (6) @(posedge sys_clk);
		rdc(OFS_MSTAT, 8'h11, "modem_status");
		rdc(OFS_MSTAT, 8'h10, "modem_status");
		modem.set_lines(4'b0100);
		repeat (6) @(posedge sys_clk);
		rdc(OFS_MSTAT, 8'h41, "modem_status");
		modem.set_lines(4'b1010);
		repeat (6) @(posedge sys_clk);
		rdc(OFS_MSTAT, 8'hAE, "modem_status");
	endtask
	// Two characters without a read in between overwrite the first
	task automatic t_rx_overrun();
		logic [7:0] n = 8'h00; // Baud high count
		wr(OFS_LCTL, 8'h80);
		wr(OFS_DATA, 8'h01);
		wr(OFS_IEN, 8'h00);
		rdc(OFS_DATA, 8'h01, "divisor_low");
		repeat (PRE_DIV) @(negedge sys_clk) n += {7'h0, baud_out};
		chk("baud_out", 8'(PRE_DIV - PRE_DIV / 2), n);
		wr(OFS_LCTL, 8'h03);
		modem.send(8'h5A);
		modem.send(8'h33);
		rdc(OFS_LSTAT, 8'h63, "line_status");
		rdc(OFS_LSTAT, 8'h61, "line_status");
		rdc(OFS_DATA, 8'h33, "rx_data");
		rdc(OFS_LSTAT, 8'h60, "line_status");
	endtask
	task automatic t_loopback();
		wr(OFS_MCTL, 8'h1F);
		repeat (8) @(posedge sys_clk);
		rdc(OFS_MSTAT, 8'hF0, "modem_status", 8'hF0);
		rdc(OFS_MSTAT, 8'hF0, "modem_status");
		wr(OFS_DATA, 8'hC3);
		rdc(OFS_LSTAT, 8'h20, "line_status");
		repeat (5000) @(posedge sys_clk);
		rdc(OFS_LSTAT, 8'h61, "line_status");
		rdc(OFS_DATA, 8'hC3, "rx_data");
		wr(OFS_IEN, 8'h02);
		@(negedge sys_clk);
		chk("irq_pin", 8'h01, {7'h0, irq_pin});
		wr(OFS_MCTL, 8'h11);
		repeat (8) @(posedge sys_clk);
		rdc(OFS_MSTAT, 8'h2D, "modem_status");
		wr(OFS_MCTL, 8'h00);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset_and_control();
		t_scratch();
		t_modem();
		t_rx_overrun();
		t_loopback();
		results();
	end
endmodule
bind umlb_uart umlb_uart_checker u_chk (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .tx_out, .terminal_ready_out_n, .request_send_out_n, .irq_oe_n);
